// ---- common/dcp_pkg.sv ----
// Shared constants, enums and carriers for the data cache policy block.
// Assumes one processor clock and a synchronous active-low reset.
package dcp_pkg;

    // ****************************************
    // Geometry and reset values
    // ****************************************
    localparam int unsigned DCP_ADDR_W   = 32;
    localparam int unsigned DCP_DATA_W   = 64;
    localparam int unsigned DCP_WAYS     = 4;
    localparam int unsigned DCP_WAY_W    = 2;
    localparam int unsigned DCP_LINE_OFS = 5;      // 32-byte line
    localparam int unsigned DCP_SETS     = 128;
    localparam int unsigned DCP_CNT_W    = 4;
    localparam logic [3:0]  DCP_CNT_RST  = 4'h0;
    localparam logic [1:0]  DCP_RC_FLUSH = 2'h2;   // Replacement control code for forced way

    // ****************************************
    // Enumerations
    // ****************************************
    typedef enum logic [1:0] {
        DCP_INV = 2'b00,
        DCP_SHR = 2'b01,
        DCP_EXC = 2'b10,
        DCP_MOD = 2'b11
    } dcp_mesi_e;

    typedef enum logic [1:0] {
        DCP_LOAD  = 2'b00,
        DCP_STORE = 2'b01,
        DCP_FLUSH = 2'b10
    } dcp_op_e;

    typedef enum logic [2:0] {
        DCP_IDLE  = 3'b000,
        DCP_LOOK  = 3'b001,
        DCP_WBACK = 3'b010,
        DCP_BUSRD = 3'b011,
        DCP_BUSWR = 3'b100
    } dcp_state_e;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        dcp_op_e                 op;
        logic                    lock;
        logic                    page_write_through_bit;
        logic                    cacheable;
        logic [DCP_ADDR_W-1:0]   addr;
        logic [DCP_DATA_W-1:0]   wdata;
    } dcp_req_s;

    typedef struct packed {
        logic                    req;
        logic                    write;
        logic                    lock;
        logic [DCP_ADDR_W-1:0]   addr;
        logic [DCP_DATA_W-1:0]   wdata;
    } dcp_bus_s;

endpackage : dcp_pkg

// ---- rtl/dcp_data_cache.sv ----
// Data cache update policy, MESI line states, replacement and locked ordering.
// Assumes one request at a time from the core and pins from the system bus.
// Function
// [R01] Write-back: write hits stay internal; modified lines leave only on replacement or flush.
// [R02] Write-through: write hits update both the cache line and memory.
// [R03] Page write-through bit overrides the line policy pin and forces write-through.
// [R04] External decoder may choose per-line policy through the line policy pin.
// [R05] Miss fill replaces the first invalid way, searching ways zero to three.
// [R06] With all ways valid, a pseudorandom counter picks the victim way.
// [R07] Replacement counters clear at reset and when the invalidate bit is written.
// [R08] In flush replacement mode the forced-way field names the victim, not the counter.
// [R09] Lines hold modified, exclusive, shared or invalid; only invalid is not valid.
// [R10] Writes to M/E stay internal, to S go bus and cache, to I bus only.
// [R11] Replacement write-backs only move a line from modified to invalid.
// [R12] Instruction cache lines are only shared or invalid.
// [R13] Read fill enters shared if policy pin low at next-address or first ready, else exclusive.
// [R14] Write-through with policy pin high moves a shared line to exclusive.
// [R15] Every locked load or store does a lookup and a bus cycle.
// [R16] Locked read of modified line stalls; cached data used if still modified.
// [R17] Locked read hitting exclusive or shared returns bus data.
// [R18] Locked read miss returns bus data; fills only if cacheable and cache-enabled.
// [R19] Locked store goes to bus; nothing starts or updates before its ready.
// [R20] A line written by a locked store stays modified.
// [R21] Earlier missing accesses finish on the bus before the first locked access.
// [R22] Nothing follows locked accesses until their last ready; fetches not serialized.
// [R23] External logic deasserts cache enable for uncacheable ranges, preventing fills.
// [R24] Invalidate bit clears all instruction cache lines and translation cache entries.
`timescale 1ns/1ps
module dcp_data_cache
    import dcp_pkg::*;
#(
    parameter int unsigned SETS = DCP_SETS
) (
    input  wire logic                  ref_clk,
    input  wire logic                  resetn,
    input  wire logic                  req_valid,
    input  wire dcp_req_s              req,
    output logic                       req_ready,
    output logic                       rsp_valid,
    output logic      [DCP_DATA_W-1:0] rsp_data,
    input  wire logic [1:0]            replacement_control_field,
    input  wire logic [DCP_WAY_W-1:0]  forced_way_field,
    input  wire logic                  cache_invalidate_bit,
    output logic                       tlb_invalidate,
    input  wire logic                  ifetch_valid,
    input  wire logic [DCP_ADDR_W-1:0] ifetch_addr,
    output logic                       ifetch_hit,
    input  wire logic                  ifill_valid,
    input  wire logic [DCP_ADDR_W-1:0] ifill_addr,
    output dcp_bus_s                   bus,
    input  wire logic                  burst_ready_n,
    input  wire logic                  next_address_request_n,
    input  wire logic                  cache_enable_input_n,
    input  wire logic                  line_policy_pin,
    input  wire logic [DCP_DATA_W-1:0] bus_rdata
);

    localparam int unsigned IDX_W = $clog2(SETS);
    localparam int unsigned TAG_W = DCP_ADDR_W - DCP_LINE_OFS - IDX_W;
    localparam int unsigned PIN_W = DCP_DATA_W + 4;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [PIN_W-1:0] pin_s1;
    logic [PIN_W-1:0] pin_s2;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            pin_s1 <= {PIN_W{1'h1}};
            pin_s2 <= {PIN_W{1'h1}};
        end else begin
            pin_s1 <= {burst_ready_n, next_address_request_n, cache_enable_input_n,
                       line_policy_pin, bus_rdata};
            pin_s2 <= pin_s1;
        end
    end

    wire                  burst_ready    = ~pin_s2[PIN_W-1];
    wire                  nxa     = ~pin_s2[PIN_W-2];
    wire                  ken     = ~pin_s2[PIN_W-3];  // [R23]
    wire                  pol_pin = pin_s2[PIN_W-4];   // [R04]
    wire [DCP_DATA_W-1:0] rdata_s = pin_s2[DCP_DATA_W-1:0];

    // ****************************************
    // Storage and lookup
    // ****************************************
    logic [TAG_W-1:0]      tag_mem  [SETS][DCP_WAYS];
    logic [DCP_DATA_W-1:0] data_mem [SETS][DCP_WAYS];
    dcp_mesi_e             st_mem   [SETS][DCP_WAYS];

    dcp_state_e            state;
    dcp_req_s              cur;
    logic                  cur_hit;
    logic [DCP_WAY_W-1:0]  cur_way;
    logic                  pol_seen;
    logic                  pol_hold;
    logic [DCP_WAYS-1:0]   hit_vec;
    logic [DCP_WAYS-1:0]   vld_vec;
    logic [DCP_WAY_W-1:0]  hit_way;
    logic [DCP_WAY_W-1:0]  vict_way;

    wire [IDX_W-1:0] idx = cur.addr[DCP_LINE_OFS +: IDX_W];
    wire [TAG_W-1:0] tag = cur.addr[DCP_ADDR_W-1 -: TAG_W];

    // Only invalid counts as not valid
    always_comb begin
        hit_vec = '0;
        vld_vec = '0;
        hit_way = '0;
        for (int w = 0; w < DCP_WAYS; w++) begin
            vld_vec[w] = (st_mem[idx][w] != DCP_INV); // [R09]
            hit_vec[w] = vld_vec[w] && (tag_mem[idx][w] == tag);
            if (hit_vec[w]) begin
                hit_way = DCP_WAY_W'(w);
            end
        end
    end

    wire flush_mode = (replacement_control_field == DCP_RC_FLUSH) || (cur.op == DCP_FLUSH);

    dcp_repl_sel #(
        .WAYS       (DCP_WAYS)
    ) u_repl (
        .ref_clk    (ref_clk),
        .resetn     (resetn),
        .invalidate (cache_invalidate_bit),
        .flush_mode (flush_mode),
        .forced_way (forced_way_field),
        .valid      (vld_vec),
        .way        (vict_way)
    );

    // ****************************************
    // Decode
    // ****************************************
    wire             hit      = |hit_vec;
    wire             in_look  = (state == DCP_LOOK);
    wire [DCP_WAY_W-1:0] wr_way = in_look ? hit_way : cur_way;
    wire dcp_mesi_e  line_st  = st_mem[idx][wr_way];
    wire dcp_mesi_e  vict_st  = st_mem[idx][vict_way];
    wire             eff_pol  = pol_seen ? pol_hold : pol_pin; // [R13]
    // Page write-through ignores the pin entirely
    wire             wb_ok    = eff_pol && !cur.page_write_through_bit; // [R03]
    wire             st_int   = (cur.op == DCP_STORE) && hit && !cur.lock
                                && !cur.page_write_through_bit                 // [R03]
                                && (line_st == DCP_MOD || line_st == DCP_EXC); // [R01] [R10]
    wire             ld_int   = (cur.op == DCP_LOAD) && hit && !cur.lock;      // [R15]
    wire             need_wb  = (vict_st == DCP_MOD) && ((cur.op == DCP_FLUSH)
                                || (!hit && cur.op == DCP_LOAD && cur.cacheable));
    wire             fill_en  = (state == DCP_BUSRD) && burst_ready && !cur_hit
                                && cur.cacheable && ken; // [R18]
    // Locked store hits update only once the bus has answered
    wire             upd_en   = (state == DCP_BUSWR) && burst_ready && cur_hit; // [R02] [R19]
    wire             wb_done  = (state == DCP_WBACK) && burst_ready;
    wire             int_wr   = in_look && st_int;
    wire dcp_mesi_e  fill_st  = wb_ok ? DCP_EXC : DCP_SHR; // [R13]
    wire dcp_mesi_e  upd_st   = int_wr               ? DCP_MOD : // [R01]
                                (line_st == DCP_MOD) ? DCP_MOD : // [R20]
                                (line_st == DCP_SHR && wb_ok) ? DCP_EXC : // [R14]
                                line_st;
    // Modified line still modified at ready: cached copy beats bus copy
    wire             use_cache = cur.lock && cur_hit && (line_st == DCP_MOD); // [R16] [R17]
    wire [DCP_DATA_W-1:0] rd_data = use_cache ? data_mem[idx][cur_way] : rdata_s;
    wire [DCP_ADDR_W-1:0] vict_addr = {tag_mem[idx][vict_way], idx, DCP_LINE_OFS'(0)};

    // ****************************************
    // Line arrays
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (fill_en) begin
            tag_mem[idx][cur_way]  <= tag;
            data_mem[idx][cur_way] <= rdata_s;
        end else if (int_wr || upd_en) begin
            data_mem[idx][wr_way] <= cur.wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            for (int s = 0; s < SETS; s++) begin
                for (int w = 0; w < DCP_WAYS; w++) begin
                    st_mem[s][w] <= DCP_INV;
                end
            end
        end else if (fill_en) begin
            st_mem[idx][cur_way] <= fill_st;
        end else if (int_wr || upd_en) begin
            st_mem[idx][wr_way] <= upd_st;
        end else if (wb_done) begin
            st_mem[idx][cur_way] <= DCP_INV; // [R11]
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    // One access in flight; req_ready stays low until its last ready
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            state     <= DCP_IDLE;
            cur       <= '0;
            cur_hit   <= 1'h0;
            cur_way   <= '0;
            req_ready <= 1'h1;
            rsp_valid <= 1'h0;
            rsp_data  <= '0;
            bus       <= '0;
            pol_seen  <= 1'h0;
            pol_hold  <= 1'h0;
        end else begin
            rsp_valid <= 1'h0;
            if ((state == DCP_BUSRD || state == DCP_BUSWR) && !pol_seen && (nxa || burst_ready)) begin
                pol_seen <= 1'h1;
                pol_hold <= pol_pin; // [R13]
            end
            unique case (state)
                DCP_IDLE: begin
                    if (req_valid && req_ready) begin
                        cur       <= req;
                        req_ready <= 1'h0; // [R21] [R22]
                        state     <= DCP_LOOK;
                    end
                end
                DCP_LOOK: begin
                    cur_hit  <= hit;
                    cur_way  <= hit ? hit_way : vict_way;
                    pol_seen <= 1'h0;
                    if (ld_int || st_int) begin
                        rsp_valid <= 1'h1;
                        rsp_data  <= ld_int ? data_mem[idx][hit_way] : '0;
                        req_ready <= 1'h1;
                        state     <= DCP_IDLE;
                    end else if (need_wb) begin
                        bus   <= '{1'h1, 1'h1, cur.lock, vict_addr, data_mem[idx][vict_way]};
                        state <= DCP_WBACK; // [R01] [R11]
                    end else if (cur.op == DCP_FLUSH) begin
                        rsp_valid <= 1'h1;
                        rsp_data  <= '0;
                        req_ready <= 1'h1;
                        state     <= DCP_IDLE;
                    end else if (cur.op == DCP_LOAD) begin
                        bus   <= '{1'h1, 1'h0, cur.lock, cur.addr, '0}; // [R15]
                        state <= DCP_BUSRD;
                    end else begin
                        bus   <= '{1'h1, 1'h1, cur.lock, cur.addr, cur.wdata}; // [R10] [R19]
                        state <= DCP_BUSWR;
                    end
                end
                DCP_WBACK: begin
                    if (burst_ready && cur.op == DCP_FLUSH) begin
                        bus       <= '0;
                        rsp_valid <= 1'h1;
                        rsp_data  <= '0;
                        req_ready <= 1'h1;
                        state     <= DCP_IDLE;
                    end else if (burst_ready) begin
                        bus   <= '{1'h1, 1'h0, cur.lock, cur.addr, '0};
                        state <= DCP_BUSRD;
                    end
                end
                DCP_BUSRD: begin
                    if (burst_ready) begin
                        bus       <= '0;
                        rsp_valid <= 1'h1;
                        rsp_data  <= rd_data; // [R16] [R17] [R18]
                        req_ready <= 1'h1;    // [R22]
                        state     <= DCP_IDLE;
                    end
                end
                DCP_BUSWR: begin
                    if (burst_ready) begin
                        bus       <= '0;
                        rsp_valid <= 1'h1;
                        rsp_data  <= '0;
                        req_ready <= 1'h1; // [R19]
                        state     <= DCP_IDLE;
                    end
                end
                default: begin
                    state     <= DCP_IDLE;
                    req_ready <= 1'h1;
                end
            endcase
        end
    end

    // ****************************************
    // Instruction cache and translation flush
    // ****************************************
    // Fetch lookups run beside the sequencer, so locked cycles never stall them
    logic [TAG_W-1:0] ic_tag [SETS];
    logic [SETS-1:0]  ic_vld;

    wire [IDX_W-1:0] f_idx = ifetch_addr[DCP_LINE_OFS +: IDX_W];
    wire [IDX_W-1:0] l_idx = ifill_addr[DCP_LINE_OFS +: IDX_W];

    always_ff @(posedge ref_clk) begin
        if (ifill_valid) begin
            ic_tag[l_idx] <= ifill_addr[DCP_ADDR_W-1 -: TAG_W];
        end
    end

    // A single valid bit: lines are only shared or invalid
    always_ff @(posedge ref_clk) begin
        if (!resetn || cache_invalidate_bit) begin
            ic_vld <= '0; // [R12] [R24]
        end else if (ifill_valid) begin
            ic_vld[l_idx] <= 1'h1; // [R12]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            ifetch_hit     <= 1'h0;
            tlb_invalidate <= 1'h0;
        end else begin
            ifetch_hit     <= ifetch_valid && ic_vld[f_idx]
                              && (ic_tag[f_idx] == ifetch_addr[DCP_ADDR_W-1 -: TAG_W]); // [R22]
            tlb_invalidate <= cache_invalidate_bit; // [R24]
        end
    end

endmodule : dcp_data_cache

// ---- rtl/dcp_repl_sel.sv ----
// Victim way selection for one four-way set.
// Assumes valid bits of the addressed set are presented by the caller.
`timescale 1ns/1ps
module dcp_repl_sel
    import dcp_pkg::*;
#(
    parameter int unsigned WAYS = DCP_WAYS
) (
    input  wire logic                 ref_clk,
    input  wire logic                 resetn,
    input  wire logic                 invalidate,
    input  wire logic                 flush_mode,
    input  wire logic [DCP_WAY_W-1:0] forced_way,
    input  wire logic [WAYS-1:0]      valid,
    output logic      [DCP_WAY_W-1:0] way
);

    logic [DCP_CNT_W-1:0] cnt;
    logic [DCP_WAY_W-1:0] free_way;
    logic                 any_free;
    wire  [DCP_WAY_W-1:0] rnd_way = cnt[1:0] ^ cnt[3:2];

    // Cleared at reset and on invalidate so identical code replays identically
    always_ff @(posedge ref_clk) begin
        if (!resetn || invalidate) begin
            cnt <= DCP_CNT_RST; // [R07]
        end else begin
            cnt <= cnt + 4'h1;
        end
    end

    // Lowest-numbered invalid way wins
    always_comb begin
        free_way = '0;
        any_free = 1'h0;
        for (int i = WAYS - 1; i >= 0; i--) begin
            if (!valid[i]) begin
                free_way = DCP_WAY_W'(i); // [R05]
                any_free = 1'h1;
            end
        end
    end

    assign way = flush_mode ? forced_way :  // [R08]
                 any_free   ? free_way   :  // [R05]
                              rnd_way;      // [R06]

endmodule : dcp_repl_sel

// ---- tb/dcp_bus_model.sv ----
// System bus model: one ready pulse per bus cycle, counts reads and writes.
// Assumes the cache holds bus.req until it has seen the ready.
`timescale 1ns/1ps
module dcp_bus_model
    import dcp_pkg::*;
(
    input  wire logic             ref_clk,
    input  wire logic             resetn,
    input  wire dcp_bus_s         bus,
    input  wire logic [3:0]       wait_cyc,
    input  wire logic             policy,
    input  wire logic             ken_n,
    output logic                  burst_ready_n,
    output logic                  next_address_request_n,
    output logic                  cache_enable_input_n,
    output logic                  line_policy_pin,
    output logic [DCP_DATA_W-1:0] bus_rdata,
    output int                    rd_cnt,
    output int                    wr_cnt
);
    logic                served;
    logic [3:0]          cnt;
    logic [DCP_ADDR_W:0] last;
    assign next_address_request_n = 1'b1;   // No pipelining offered
    assign cache_enable_input_n   = ken_n;
    assign line_policy_pin        = policy;
    always_ff @(posedge ref_clk) begin
        burst_ready_n <= 1'b1;
        bus_rdata     <= ~bus_rdata;        // Released data must not look valid
        if (!resetn) begin
            served <= 1'b0;
            cnt    <= 4'h0;
            rd_cnt <= 0;
            wr_cnt <= 0;
        end else if (!bus.req || {bus.write, bus.addr} != last) begin
            served <= 1'b0;
            cnt    <= 4'h0;
            last   <= {bus.write, bus.addr};
        end else if (!served && cnt == wait_cyc) begin
            burst_ready_n <= 1'b0;
            bus_rdata     <= {bus.addr ^ 32'h5A5A_0000, bus.addr};
            served        <= 1'b1;
            if (bus.write) wr_cnt <= wr_cnt + 1;
            else rd_cnt <= rd_cnt + 1;
        end else if (!served) begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule : dcp_bus_model

// ---- tb/dcp_chk.sv ----
// Port checker for the data cache policy block.
// Assumes it is bound to dcp_data_cache with one clock and sync reset.
`timescale 1ns/1ps
module dcp_chk
    import dcp_pkg::*;
(
    input wire logic     ref_clk,
    input wire logic     resetn,
    input wire logic     req_valid,
    input wire dcp_req_s req,
    input wire logic     req_ready,
    input wire logic     rsp_valid,
    input wire logic     cache_invalidate_bit,
    input wire logic     tlb_invalidate,
    input wire dcp_bus_s bus,
    input wire logic     burst_ready_n
);
    // ****
    // Properties
    // ****
    default clocking dcp_cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);
    sequence s_take;
        req_valid && req_ready;
    endsequence
    sequence s_seen;
        bus.req && !burst_ready_n;
    endsequence
    busy_after_take_a: assert property (s_take |=> !req_ready)
        else $error("request accepted while busy");
    rsp_one_cycle_a: assert property (rsp_valid |=> !rsp_valid)
        else $error("response longer than one cycle");
    rsp_frees_core_a: assert property (rsp_valid |-> req_ready)
        else $error("response without ready");
    tlb_follows_bit_a: assert property (tlb_invalidate == $past(cache_invalidate_bit))
        else $error("translation invalidate mistimed");
    bus_holds_a: assert property (bus.req && $past(bus.req) && $past(burst_ready_n, 3)
                                  |-> $stable(bus))
        else $error("bus request changed while pending");
    bus_release_a: assert property (s_seen |-> ##[1:4] !$stable(bus))
        else $error("bus request not released");
    read_ends_rsp_a: assert property ($fell(bus.req) && !$past(bus.write) |-> rsp_valid)
        else $error("read finished without response");
    lock_goes_bus_a: assert property ((s_take ##0 req.lock) |-> ##[1:3] bus.req)
        else $error("locked access without bus cycle");
    idle_bus_quiet_a: assert property (req_ready |-> !bus.req)
        else $error("bus active while core is free");
endmodule : dcp_chk

bind dcp_data_cache dcp_chk dcp_chk_i (
    .ref_clk, .resetn, .req_valid, .req, .req_ready, .rsp_valid,
    .cache_invalidate_bit, .tlb_invalidate, .bus, .burst_ready_n
);

// ---- tb/test_dcp_data_cache.sv ----
// Self-checking bench for the data cache policy block.
// Assumes dcp_bus_model as the system bus and dcp_chk bound to the design.
`timescale 1ns/1ps
module test_dcp_data_cache
    import dcp_pkg::*;
;
    logic        ref_clk = 1'b0, resetn = 1'b0, req_valid = 1'b0, cach = 1'b1;
    dcp_req_s    req = '0;
    logic [1:0]  rcf = 2'h0, fw = 2'h0;
    logic        inv = 1'b0, ifetch_valid = 1'b0, ifill_valid = 1'b0;
    logic [31:0] ifetch_addr = 32'h0, ifill_addr = 32'h0;
    logic        req_ready, rsp_valid, tlb_invalidate, ifetch_hit;
    logic [63:0] rsp_data, bus_rdata;
    dcp_bus_s    bus;
    logic        rdy_n, na_n, ken_pin_n, pol_pin, policy = 1'b0, ken_n = 1'b0;
    logic [3:0]  wait_cyc = 4'h0;
    int          rd_cnt, wr_cnt, err_count = 0, total_checks = 0;

    always #50 ref_clk = ~ref_clk;

    dcp_data_cache dcp_data_cache_i (
        .ref_clk, .resetn, .req_valid, .req, .req_ready, .rsp_valid, .rsp_data,
        .replacement_control_field(rcf), .forced_way_field(fw),
        .cache_invalidate_bit(inv), .tlb_invalidate, .ifetch_valid, .ifetch_addr,
        .ifetch_hit, .ifill_valid, .ifill_addr, .bus, .burst_ready_n(rdy_n),
        .next_address_request_n(na_n), .cache_enable_input_n(ken_pin_n),
        .line_policy_pin(pol_pin), .bus_rdata);
    dcp_bus_model dcp_bus_model_i (
        .ref_clk, .resetn, .bus, .wait_cyc, .policy, .ken_n, .burst_ready_n(rdy_n),
        .next_address_request_n(na_n), .cache_enable_input_n(ken_pin_n),
        .line_policy_pin(pol_pin), .bus_rdata, .rd_cnt, .wr_cnt);

    // ****
    // Shared tasks
    // ****
    function automatic logic [63:0] pat(input logic [31:0] a);
        return {a ^ 32'h5A5A_0000, a};
    endfunction : pat

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One core access; bus cycle counts tell internal from external handling
    task automatic acc(input dcp_op_e op, input logic lk, input logic pwt, input logic [31:0] a,
                       input logic [63:0] wd, input int nrd, input int nwr,
                       input logic [63:0] exp);
        int r0, w0, n;
        r0 = rd_cnt;
        w0 = wr_cnt;
        n = 0;
        @(negedge ref_clk);
        req_valid = 1'b1;
        req = '{op, lk, pwt, cach, a, wd};
        @(negedge ref_clk);
        req_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 200) begin
            @(negedge ref_clk);
            n++;
        end
        check(64'(n < 200), 64'h1);
        check(rsp_data, exp);
        check(64'(rd_cnt - r0), 64'(nrd));
        check(64'(wr_cnt - w0), 64'(nwr));
    endtask : acc

    // ****
    // Scenarios
    // ****
    task automatic t_policy();
        policy = 1'b0;
        acc(DCP_LOAD, 0, 0, 32'h40, '0, 1, 0, pat(32'h40));
        acc(DCP_LOAD, 0, 0, 32'h40, '0, 0, 0, pat(32'h40));
        policy = 1'b1;
        acc(DCP_STORE, 0, 0, 32'h40, 64'h11, 0, 1, '0);
        acc(DCP_STORE, 0, 0, 32'h40, 64'h22, 0, 0, '0);
        acc(DCP_LOAD, 0, 0, 32'h40, '0, 0, 0, 64'h22);
        acc(DCP_STORE, 0, 1, 32'h40, 64'h33, 0, 1, '0);
    endtask : t_policy

    task automatic t_lock();
        wait_cyc = 4'h5;
        acc(DCP_LOAD, 1, 0, 32'h40, '0, 1, 0, 64'h33);
        acc(DCP_STORE, 1, 0, 32'h40, 64'h44, 0, 1, '0);
        acc(DCP_STORE, 0, 0, 32'h40, 64'h55, 0, 0, '0);
        acc(DCP_LOAD, 0, 0, 32'h40, '0, 0, 0, 64'h55);
        policy = 1'b0;
        acc(DCP_LOAD, 0, 0, 32'h80, '0, 1, 0, pat(32'h80));
        policy = 1'b1;
        acc(DCP_STORE, 0, 0, 32'h80, 64'h66, 0, 1, '0);
        acc(DCP_LOAD, 1, 0, 32'h80, '0, 1, 0, pat(32'h80));
        wait_cyc = 4'h0;
    endtask : t_lock

    task automatic t_ken();
        ken_n = 1'b1;
        acc(DCP_LOAD, 1, 0, 32'hC0, '0, 1, 0, pat(32'hC0));
        acc(DCP_LOAD, 0, 0, 32'hC0, '0, 1, 0, pat(32'hC0));
        ken_n = 1'b0;
        acc(DCP_LOAD, 0, 0, 32'hC0, '0, 1, 0, pat(32'hC0));
        acc(DCP_LOAD, 0, 0, 32'hC0, '0, 0, 0, pat(32'hC0));
        cach = 1'b0;
        acc(DCP_LOAD, 0, 0, 32'h100, '0, 1, 0, pat(32'h100));
        acc(DCP_LOAD, 0, 0, 32'h100, '0, 1, 0, pat(32'h100));
        cach = 1'b1;
    endtask : t_ken

    // Line k fills way k; forcing way 2 evicts line 2
    task automatic t_repl();
        policy = 1'b0;
        for (int k = 0; k < 8; k++) acc(DCP_LOAD, 0, 0, 32'hA0 + k[1:0] * 32'h1000, '0,
                                         int'(k < 4), 0, pat(32'hA0 + k[1:0] * 32'h1000));
        rcf = DCP_RC_FLUSH;
        fw = 2'h2;
        acc(DCP_LOAD, 0, 0, 32'h40A0, '0, 1, 0, pat(32'h40A0));
        acc(DCP_LOAD, 0, 0, 32'h00A0, '0, 0, 0, pat(32'h00A0));
        acc(DCP_LOAD, 0, 0, 32'h20A0, '0, 1, 0, pat(32'h20A0));
        rcf = 2'h0;
    endtask : t_repl

    task automatic t_flush();
        policy = 1'b1;
        fw = 2'h0;
        acc(DCP_STORE, 0, 0, 32'hA0, 64'h77, 0, 1, '0);
        acc(DCP_STORE, 0, 0, 32'hA0, 64'h88, 0, 0, '0);
        acc(DCP_FLUSH, 0, 0, 32'hA0, '0, 0, 1, '0);
        acc(DCP_LOAD, 0, 0, 32'hA0, '0, 1, 0, pat(32'hA0));
        acc(DCP_FLUSH, 0, 0, 32'hA0, '0, 0, 0, '0);
    endtask : t_flush

    task automatic t_icache();
        @(negedge ref_clk);
        ifill_valid = 1'b1;
        ifill_addr = 32'h2000;
        @(negedge ref_clk);
        ifill_valid = 1'b0;
        ifetch_valid = 1'b1;
        ifetch_addr = 32'h2000;
        @(negedge ref_clk);
        check(64'(ifetch_hit), 64'h1);
        ifetch_valid = 1'b0;
        inv = 1'b1;
        @(negedge ref_clk);
        check(64'(tlb_invalidate), 64'h1);
        inv = 1'b0;
        ifetch_valid = 1'b1;
        @(negedge ref_clk);
        check(64'(ifetch_hit), 64'h0);
        ifetch_valid = 1'b0;
    endtask : t_icache

    task automatic wrap_up();
        if (err_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up

    initial begin
        repeat (20) @(negedge ref_clk);
        resetn = 1'b1;
        t_policy();
        t_lock();
        t_ken();
        t_repl();
        t_flush();
        t_icache();
        wrap_up();
    end

    // 35 accesses under 30 cycles each; a hang trips this
    initial begin
        repeat (5000) @(posedge ref_clk);
        err_count++;
        wrap_up();
    end
endmodule : test_dcp_data_cache
